// [testbench/rx_serial_core_asserts.sv]
// Port-level checks for the serial receiver, bound to its top module.
module rx_serial_core_asserts (
  input wire logic                            ref_clk,
  input wire logic                            rst,
  input wire logic                            ce,
  input wire logic                            receive_line,
  input wire logic                            sleep_mode,
  input wire logic [uart_rx_pkg::ADDR_W-1:0] avs_address,
  input wire logic                            avs_read,
  input wire logic                            avs_write,
  input wire logic [31:0]                     avs_writedata,
  input wire logic [3:0]                      avs_byteenable,
  input wire logic [31:0]                     avs_readdata,
  input wire logic                            avs_waitrequest,
  input wire logic                            receive_irq,
  input wire logic                            receive_irq_priority
);
  timeunit 1ns;
  timeprecision 1ns;
  import uart_rx_pkg::*;

  logic ie_q;
  logic ie_d;

  // Shadow of the request enable, taken when a write is answered.
  always_comb begin
    ie_d = ie_q;
    if (avs_write && !avs_waitrequest && ce && avs_byteenable[0] &&
        avs_address == OFS_IRQ_CTRL) begin
      ie_d = avs_writedata[IC_RECEIVE_IRQ_ENABLE];
    end
  end

  // Registered copy; cleared by reset like the design's own bit.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ie_q <= 1'b0;
    end else begin
      ie_q <= ie_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_wait_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
    else $error("bus request not answered after one wait state");
  a_wait_single: assert property (
    !avs_waitrequest && ce |=> avs_waitrequest)
    else $error("answer cycle lasted more than one clock");
  a_read_pad: assert property (
    avs_readdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_unmapped_zero: assert property (
    avs_read && !avs_waitrequest && avs_address == 3'h7 |->
    avs_readdata == 32'h0)
    else $error("unmapped word did not read zero");
  a_data_hold: assert property (
    (!avs_read && !avs_write) [*2] |-> $stable(avs_readdata))
    else $error("read data changed while bus idle");
  a_reset_quiet: assert property (
    $fell(rst) |-> avs_waitrequest && !receive_irq && avs_readdata == 32'h0)
    else $error("outputs not quiet after reset");
  a_irq_gated: assert property (
    receive_irq |-> ie_q || $past(ie_q))
    else $error("request raised while its enable was clear");
  a_prio_under_irq: assert property (
    receive_irq_priority |-> receive_irq || $past(receive_irq))
    else $error("priority request without receive request");

  c_irq_rise: cover property ($rose(receive_irq));
  c_prio_rise: cover property ($rose(receive_irq_priority));
  c_data_read: cover property (
    avs_read && !avs_waitrequest && avs_address == OFS_RX_DATA);
endmodule : rx_serial_core_asserts

bind rx_serial_core rx_serial_core_asserts rx_serial_core_asserts_inst (
  .ref_clk(ref_clk), .rst(rst), .ce(ce), .receive_line(receive_line),
  .sleep_mode(sleep_mode), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .receive_irq(receive_irq), .receive_irq_priority(receive_irq_priority)
);

// [testbench/serial_sender.sv]
// Behavioural remote transmitter that drives the receive line.
module serial_sender (
  input  wire logic ref_clk,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ns;

  // The line idles high, as the pulled-up pin does between frames.
  initial line = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // start, data, stop.
  // A low stop level is only sent when the bench asks for a bad frame.
  task automatic send(input logic [11:0] d, input int nb, input logic stp,
                      input int bc);
    for (int i = 0; i <= nb + 1; i++) begin
      line <= (i == 0) ? 1'b0 : (i > nb) ? stp : d[i-1];
      repeat (bc) @(posedge ref_clk);
    end
    // Two idle bit times keep the next start edge clean.
    line <= 1'b1;
    repeat (2 * bc) @(posedge ref_clk);
  endtask : send
endmodule : serial_sender

// [testbench/tb_top.sv]
// Self-checking bench for the serial receiver with auto-wake.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import uart_rx_pkg::*;

  logic              ref_clk, rst, ce, rx_line, sleep_mode, ovr;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read, avs_write, avs_waitrequest;
  logic              receive_irq, irq_prio;
  logic [31:0]       avs_writedata, avs_readdata, rd;
  logic [3:0]        avs_byteenable;
  logic [7:0]        ctl, icw;
  int                n_errors, cmp_count, seed, bt;
  int                q[$];

  rx_serial_core rx_serial_core_inst (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .receive_line(rx_line),
    .sleep_mode(sleep_mode), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .receive_irq(receive_irq), .receive_irq_priority(irq_prio));
  serial_sender serial_sender_inst (.ref_clk(ref_clk), .line(rx_line));

  // Free-running 50 ns clock and a watchdog that cuts a hang short.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    n_errors++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk8

  task automatic chk1(input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk1

  // One bus cycle; held until waitrequest is sampled low, then released.
  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [7:0] d, input logic [3:0] be);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      summarize();
    end
  endtask : bus

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    chk8(e, rd[7:0]);
  endtask : rchk

  // Sends a frame and updates the two-word model buffer.
  task automatic frame(input logic [8:0] d, input int nb, input logic stp,
                       input logic take);
    serial_sender_inst.send({3'h0, d}, nb, stp, bt);
    if (take && !ovr) begin
      if (q.size() < 2) q.push_back({22'h0, !stp, d});
      else ovr = 1'b1;
    end
  endtask : frame

  task automatic pop();
    int w;
    w = q.pop_front();
    rchk(OFS_RX_STATUS, ctl | {5'h0, w[9], ovr, w[8]});
    rchk(OFS_RX_DATA, w[7:0]);
  endtask : pop

  task automatic flag_chk(input logic f);
    rchk(OFS_IRQ_CTRL, icw | {7'h0, f});
    chk1(f & icw[1], receive_irq);
    chk1(f & icw[1] & icw[2], irq_prio);
  endtask : flag_chk

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; ce is the only input tied for the whole run.
  initial begin
    seed = 32'hc349;
    bt = 16;
    {n_errors, cmp_count} = 0;
    {rst, ce, sleep_mode, ovr, ctl, icw} = {4'hC, 16'h0};
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    // Every word reads zero after reset except the receiver idle bit.
    for (int a = 0; a < 8; a++) begin
      rchk(3'(a), (a == 3) ? 8'h40 : 8'h00);
    end
    // fastest tick, divisor zero, so a bit lasts 16 clocks.
    wr(OFS_TX_STATUS, 8'h04);
    wr(OFS_BAUD_CTRL, 8'h08);
    wr(OFS_DIV_LOW, 8'hA5);
    bus(1'b1, OFS_DIV_LOW, 8'h00, 4'h0);
    rchk(OFS_DIV_LOW, 8'hA5);
    wr(OFS_DIV_LOW, 8'h00);
    icw = 8'h06;
    wr(OFS_IRQ_CTRL, icw);
    ctl = 8'h90;
    wr(OFS_RX_STATUS, ctl);
    $display("end of setup");
    // random bytes each completed and read back.
    for (int i = 0; i < 4; i++) begin
      frame({1'b0, 8'($random(seed))}, 8, 1'b1, 1'b1);
      flag_chk(1'b1);
      pop();
    end
    flag_chk(1'b0);
    frame(9'h0C3, 8, 1'b0, 1'b1);
    pop();
    $display("end of plain frames");
    // third unread word overruns; clearing receive recovers.
    icw = 8'h00;
    wr(OFS_IRQ_CTRL, icw);
    for (int i = 0; i < 3; i++) frame({1'b0, 8'($random(seed))}, 8, 1'b1, 1'b1);
    flag_chk(1'b1);
    pop();
    pop();
    ctl = 8'h80;
    wr(OFS_RX_STATUS, ctl);
    ovr = 1'b0;
    rchk(OFS_RX_STATUS, 8'h80);
    $display("end of overrun");
    // address filter keeps only ninth-bit-one words.
    icw = 8'h06;
    wr(OFS_IRQ_CTRL, icw);
    ctl = 8'hD8;
    wr(OFS_RX_STATUS, ctl);
    frame(9'h055, 9, 1'b1, 1'b0);
    flag_chk(1'b0);
    frame(9'h1A7, 9, 1'b1, 1'b1);
    pop();
    ctl = 8'hD0;
    wr(OFS_RX_STATUS, ctl);
    frame(9'h03C, 9, 1'b1, 1'b1);
    pop();
    $display("end of address detect");
    // middle prescale; the high divisor byte counts only when wide.
    bt = 64;
    wr(OFS_BAUD_CTRL, 8'h00);
    wr(OFS_DIV_HIGH, 8'h3C);
    ctl = 8'hB0;
    wr(OFS_RX_STATUS, ctl);
    frame({1'b0, 8'($random(seed))}, 8, 1'b1, 1'b1);
    pop();
    rchk(OFS_DIV_HIGH, 8'h3C);
    wr(OFS_DIV_HIGH, 8'h00);
    wr(OFS_BAUD_CTRL, 8'h08);
    bt = 16;
    $display("end of slow rate");
    // synchronous select and sleep both block reception.
    ctl = 8'h90;
    wr(OFS_RX_STATUS, ctl);
    wr(OFS_TX_STATUS, 8'h14);
    frame(9'h0AA, 8, 1'b1, 1'b0);
    wr(OFS_TX_STATUS, 8'h04);
    sleep_mode <= 1'b1;
    frame(9'h0A5, 8, 1'b1, 1'b0);
    sleep_mode <= 1'b0;
    flag_chk(1'b0);
    $display("end of blocked reception");
    // a falling edge wakes the block while asleep.
    wr(OFS_BAUD_CTRL, 8'h0A);
    sleep_mode <= 1'b1;
    fork
      serial_sender_inst.send(12'h000, 12, 1'b1, 16);
      begin
        repeat (80) @(posedge ref_clk);
        chk1(1'b1, receive_irq);
      end
    join
    sleep_mode <= 1'b0;
    flag_chk(1'b1);
    bus(1'b0, OFS_BAUD_CTRL, 8'h00, 4'hF);
    chk8(8'h48, rd[7:0]);
    // No word may have landed while the receiver idled for the wake.
    rchk(OFS_RX_STATUS, ctl);
    // the word read after a wake is dummy and dropped.
    bus(1'b0, OFS_RX_DATA, 8'h00, 4'hF);
    flag_chk(1'b0);
    frame({1'b0, 8'($random(seed))}, 8, 1'b1, 1'b1);
    pop();
    $display("end of auto-wake");
    summarize();
  end
endmodule : tb_top

// [verilog/baud_tick_gen.sv]
// Sample clock generator producing one tick per oversampling slot.
module baud_tick_gen (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire uart_rx_pkg::baud_cfg_type cfg,
  output logic                           tick_q
);
  import uart_rx_pkg::*;

  typedef struct packed {
    logic [4:0]  pre;
    logic [15:0] div;
    logic        tick;
  } gen_state_type;

  gen_state_type s_q;
  gen_state_type s_d;
  logic [4:0]    pre_limit;
  logic [15:0]   div_limit;

  // Both selects set give the fastest counter clock, neither the slowest.
  always_comb begin
    unique case ({cfg.wide, cfg.high_speed})
      2'b11:   pre_limit = PRESCALE_FAST;
      2'b00:   pre_limit = PRESCALE_SLOW;
      default: pre_limit = PRESCALE_MID;
    endcase
    div_limit = cfg.wide ? cfg.divisor : {8'h00, cfg.divisor[7:0]};
  end

  // Divide by prescale times (divisor + 1); held in reset while disabled.
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!cfg.enable) begin
      s_d = '0;
    end else if (s_q.pre + 5'h01 < pre_limit) begin
      s_d.pre = s_q.pre + 5'h01;
    end else begin
      s_d.pre = '0;
      if (s_q.div >= div_limit) begin
        s_d.div  = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.div = s_q.div + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign tick_q = s_q.tick;

endmodule : baud_tick_gen

// [verilog/line_sync.sv]
// Two-stage synchroniser for the asynchronous receive pin.
module line_sync (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic line_in,
  output logic      line_q
);
  import uart_rx_pkg::*;

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_type;

  sync_state_type s_q;
  sync_state_type s_d;

  // The first stage feeds only the second; the idle line level is high.
  always_comb begin
    s_d        = s_q;
    s_d.meta   = line_in;
    s_d.stable = s_q.meta;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, frozen while the clock enable is low.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '{meta: 1'b1, stable: 1'b1};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign line_q = s_q.stable;

endmodule : line_sync

// [verilog/rx_serial_core.sv]
// Asynchronous serial receiver with address filter and auto-wake.
module rx_serial_core (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic                       receive_line,
  input  wire logic                       sleep_mode,
  input  wire logic [uart_rx_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  output logic                            receive_irq,
  output logic                            receive_irq_priority
);
  import uart_rx_pkg::*;

  typedef struct packed {
    logic                  waitreq;
    logic [31:0]           rdata;
    logic                  serial_port_enable;
    logic                  nine;
    logic                  single;
    logic                  continuous_receive_enable;
    logic                  address_detect_enable;
    logic                  overrun;
    logic                  sync_mode;
    logic                  high_speed;
    logic                  wide;
    logic                  wake_up_enable;
    logic [7:0]            div_hi;
    logic [7:0]            div_lo;
    logic                  rie;
    logic                  rip;
    logic                  irq;
    logic                  irq_pri;
    rx_word_type [1:0]     buf_w;
    logic [1:0]            count;
    logic                  wake_flag;
    logic                  wake_seen;
    rx_state_type          state;
    logic [3:0]            smp;
    logic [3:0]            bits;
    logic [2:0]            win;
    logic [8:0]            shift;
    logic                  line_prev;
  } core_state_type;

  core_state_type s_q;
  core_state_type s_d;
  baud_cfg_type   baud_cfg;
  logic           line_s;
  logic           tick;

  // Two of three samples around mid-bit decide the bit level.
  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : majority

  // Receive flag: unread words or a pending wake event.
  function automatic logic flag_of(input core_state_type s);
    flag_of = (s.count != 2'h0) | s.wake_flag;
  endfunction : flag_of

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and sample clock generator.
  line_sync u_line_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .line_in (receive_line),
    .line_q  (line_s)
  );

  assign baud_cfg = '{enable:     s_q.serial_port_enable & ~s_q.sync_mode & ~sleep_mode,
                      high_speed: s_q.high_speed,
                      wide:       s_q.wide,
                      divisor:    {s_q.div_hi, s_q.div_lo}};

  baud_tick_gen u_baud_tick_gen (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .cfg     (baud_cfg),
    .tick_q  (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus slave first, then wake logic, then the receiver,
  // so that hardware sets made in the same cycle win over software clears.
  always_comb begin
    logic        async_mode;
    logic        active;
    logic        fall;
    logic        rise;
    logic        bit_val;
    logic [31:0] rv;
    rx_word_type word;
    async_mode = 1'b0;
    active     = 1'b0;
    fall       = 1'b0;
    rise       = 1'b0;
    bit_val    = 1'b0;
    rv         = 32'h0000_0000;
    word       = '0;
    s_d        = s_q;

    // Read mux; unmapped words and unused bits read as zero.
    unique case (avs_address)
      OFS_RX_STATUS: begin
        rv[RS_SERIAL_PORT_ENABLE] = s_q.serial_port_enable;
        rv[RS_NINE_BIT_SELECT]    = s_q.nine;
        rv[RS_SINGLE_RECEIVE]     = s_q.single;
        rv[RS_CONT_RECEIVE]       = s_q.continuous_receive_enable;
        rv[RS_ADDRESS_DETECT]     = s_q.address_detect_enable;
        rv[RS_FRAMING_ERROR]      = s_q.buf_w[0].framing;
        rv[RS_OVERRUN_ERROR]      = s_q.overrun;
        rv[RS_NINTH_BIT]          = s_q.buf_w[0].ninth;
      end
      OFS_RX_DATA:   rv[7:0] = s_q.buf_w[0].data;
      OFS_TX_STATUS: begin
        rv[TS_SYNC_MODE]       = s_q.sync_mode;
        rv[TS_HIGH_SPEED_BAUD] = s_q.high_speed;
      end
      OFS_BAUD_CTRL: begin
        rv[BC_RECEIVER_IDLE]  = (s_q.state == RX_IDLE);
        rv[BC_WIDE_GENERATOR] = s_q.wide;
        rv[BC_WAKE_UP_ENABLE] = s_q.wake_up_enable;
      end
      OFS_DIV_HIGH:  rv[7:0] = s_q.div_hi;
      OFS_DIV_LOW:   rv[7:0] = s_q.div_lo;
      OFS_IRQ_CTRL:  begin
        rv[IC_RECEIVE_FLAG]       = flag_of(s_q);
        rv[IC_RECEIVE_IRQ_ENABLE] = s_q.rie;
        rv[IC_RECEIVE_IRQ_PRIO]   = s_q.rip;
      end
      default:       rv = 32'h0000_0000;
    endcase

    // One wait state: data latched on entry, effects at the release edge.
    if (s_q.waitreq && (avs_read || avs_write)) begin
      s_d.waitreq = 1'b0;
      s_d.rdata   = avs_write ? 32'h0000_0000 : rv;
    end else if (!s_q.waitreq) begin
      s_d.waitreq = 1'b1;
      if (avs_write && avs_byteenable[0]) begin
        unique case (avs_address)
          OFS_RX_STATUS: begin
            s_d.serial_port_enable   = avs_writedata[RS_SERIAL_PORT_ENABLE];
            s_d.nine   = avs_writedata[RS_NINE_BIT_SELECT];
            s_d.single = avs_writedata[RS_SINGLE_RECEIVE];
            s_d.continuous_receive_enable   = avs_writedata[RS_CONT_RECEIVE];
            s_d.address_detect_enable  = avs_writedata[RS_ADDRESS_DETECT];
            if (!avs_writedata[RS_CONT_RECEIVE]) begin
              s_d.overrun = 1'b0;
            end
          end
          OFS_TX_STATUS: begin
            s_d.sync_mode  = avs_writedata[TS_SYNC_MODE];
            s_d.high_speed = avs_writedata[TS_HIGH_SPEED_BAUD];
          end
          OFS_BAUD_CTRL: begin
            s_d.wide = avs_writedata[BC_WIDE_GENERATOR];
            s_d.wake_up_enable  = avs_writedata[BC_WAKE_UP_ENABLE];
          end
          OFS_DIV_HIGH:  s_d.div_hi = avs_writedata[7:0];
          OFS_DIV_LOW:   s_d.div_lo = avs_writedata[7:0];
          OFS_IRQ_CTRL:  begin
            s_d.rie = avs_writedata[IC_RECEIVE_IRQ_ENABLE];
            s_d.rip = avs_writedata[IC_RECEIVE_IRQ_PRIO];
          end
          default:       s_d.rip = s_q.rip;
        endcase
      end
      if (avs_read && avs_address == OFS_RX_DATA) begin
        s_d.wake_flag = 1'b0;
        if (s_q.count != 2'h0) begin
          s_d.buf_w[0] = s_q.buf_w[1];
          s_d.count    = s_q.count - 2'h1;
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Line edges, seen only through the synchronised copy.
    fall          = s_q.line_prev & ~line_s;
    rise          = ~s_q.line_prev & line_s;
    s_d.line_prev = line_s;
    async_mode    = s_d.serial_port_enable & ~s_d.sync_mode;

    // Wake watch runs even in sleep, because it needs no generator tick.
    // wake in async only
    if (async_mode && s_d.wake_up_enable) begin
      if (!s_q.wake_seen && fall) begin
        s_d.wake_seen = 1'b1;
        s_d.wake_flag = 1'b1;
      end else if (s_q.wake_seen && rise) begin
        s_d.wake_seen = 1'b0;
        s_d.wake_up_enable       = 1'b0;
      end
    end else begin
      s_d.wake_seen = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver; an overrun halts it until the error is cleared.
    // reception idles in wake
    active = async_mode & s_d.continuous_receive_enable & ~s_d.overrun & ~s_q.wake_up_enable
             & ~sleep_mode;
    bit_val = majority({s_q.win[1:0], line_s});
    if (!active) begin
      s_d.state = RX_IDLE;
    end else if (s_q.state == RX_IDLE) begin
      if (fall) begin
        s_d.state = RX_START;
        s_d.smp   = 4'h0;
        s_d.bits  = 4'h0;
      end
    end else if (tick) begin
      s_d.win = {s_q.win[1:0], line_s};
      s_d.smp = s_q.smp + 4'h1;
      unique case (s_q.state)
        RX_START: begin
          if (s_q.smp == SAMPLE_MID && bit_val) begin
            s_d.state = RX_IDLE;
          end else if (s_q.smp == SAMPLE_LAST) begin
            s_d.state = RX_DATA;
          end
        end
        RX_DATA: begin
          if (s_q.smp == SAMPLE_MID) begin
            s_d.shift = {bit_val, s_q.shift[8:1]};
          end
          if (s_q.smp == SAMPLE_LAST) begin
            if (s_q.bits == (s_q.nine ? LAST_BIT_NINE : LAST_BIT_EIGHT)) begin
              s_d.state = RX_STOP;
            end else begin
              s_d.bits = s_q.bits + 4'h1;
            end
          end
        end
        RX_STOP: begin
          if (s_q.smp == SAMPLE_MID) begin
            s_d.state = RX_IDLE;
            word.framing = ~bit_val;
            if (s_q.nine) begin
              word.ninth = s_q.shift[8];
              word.data  = s_q.shift[7:0];
            end else begin
              word.ninth = 1'b0;
              word.data  = s_q.shift[8:1];
            end
            if (!(s_q.address_detect_enable && s_q.nine && !word.ninth)) begin
              if (s_d.count == BUFFER_DEPTH) begin
                s_d.overrun = 1'b1;
              end else begin
                s_d.buf_w[s_d.count[0]] = word;
                s_d.count               = s_d.count + 2'h1;
              end
            end
          end
        end
        default: s_d.state = RX_IDLE;
      endcase
    end

    s_d.irq     = flag_of(s_d) & s_d.rie;
    s_d.irq_pri = flag_of(s_d) & s_d.rie & s_d.rip;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; the whole block freezes while the clock enable is low.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q           <= '0;
      s_q.waitreq   <= 1'b1;
      s_q.div_hi    <= DIVISOR_RESET;
      s_q.div_lo    <= DIVISOR_RESET;
      s_q.line_prev <= 1'b1;
      s_q.state     <= RX_IDLE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs come straight from the state register.
  assign avs_readdata         = s_q.rdata;
  assign avs_waitrequest      = s_q.waitreq;
  assign receive_irq          = s_q.irq;
  assign receive_irq_priority = s_q.irq_pri;

endmodule : rx_serial_core

// [verilog/uart_rx_pkg.sv]
// Shared constants and carrier types for the serial receiver block.
package uart_rx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register word indices on the Avalon-MM slave (one 32-bit word each).
  localparam int unsigned ADDR_W        = 3;
  localparam logic [2:0]  OFS_RX_STATUS = 3'h0;
  localparam logic [2:0]  OFS_RX_DATA   = 3'h1;
  localparam logic [2:0]  OFS_TX_STATUS = 3'h2;
  localparam logic [2:0]  OFS_BAUD_CTRL = 3'h3;
  localparam logic [2:0]  OFS_DIV_HIGH  = 3'h4;
  localparam logic [2:0]  OFS_DIV_LOW   = 3'h5;
  localparam logic [2:0]  OFS_IRQ_CTRL  = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in receive_status_control.
  localparam int unsigned RS_SERIAL_PORT_ENABLE = 7;
  localparam int unsigned RS_NINE_BIT_SELECT    = 6;
  localparam int unsigned RS_SINGLE_RECEIVE     = 5;
  localparam int unsigned RS_CONT_RECEIVE       = 4;
  localparam int unsigned RS_ADDRESS_DETECT     = 3;
  localparam int unsigned RS_FRAMING_ERROR      = 2;
  localparam int unsigned RS_OVERRUN_ERROR      = 1;
  localparam int unsigned RS_NINTH_BIT          = 0;
  // Field positions in transmit_status_control.
  localparam int unsigned TS_SYNC_MODE          = 4;
  localparam int unsigned TS_HIGH_SPEED_BAUD    = 2;
  // Field positions in baud_control.
  localparam int unsigned BC_RECEIVER_IDLE      = 6;
  localparam int unsigned BC_WIDE_GENERATOR     = 3;
  localparam int unsigned BC_WAKE_UP_ENABLE     = 1;
  // Field positions in the interrupt control word.
  localparam int unsigned IC_RECEIVE_FLAG       = 0;
  localparam int unsigned IC_RECEIVE_IRQ_ENABLE = 1;
  localparam int unsigned IC_RECEIVE_IRQ_PRIO   = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and timing counts.
  localparam logic [7:0]  DIVISOR_RESET   = 8'h00;
  localparam logic [3:0]  SAMPLE_MID      = 4'h9;
  localparam logic [3:0]  SAMPLE_LAST     = 4'hF;
  localparam logic [3:0]  LAST_BIT_EIGHT  = 4'h7;
  localparam logic [3:0]  LAST_BIT_NINE   = 4'h8;
  localparam logic [4:0]  PRESCALE_FAST   = 5'h01;
  localparam logic [4:0]  PRESCALE_MID    = 5'h04;
  localparam logic [4:0]  PRESCALE_SLOW   = 5'h10;
  localparam logic [1:0]  BUFFER_DEPTH    = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types.
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;

  typedef struct packed {
    logic       framing;
    logic       ninth;
    logic [7:0] data;
  } rx_word_type;

  typedef struct packed {
    logic        enable;
    logic        high_speed;
    logic        wide;
    logic [15:0] divisor;
  } baud_cfg_type;

endpackage : uart_rx_pkg
